//--- core/lapc_top.sv
/*
 lapc_top: configuration register of the serial management interface, with the
 locked-access answer logic for LPC cycles and the activation readback option.
 assumes: Avalon-MM master on CLK; LPC cycle attributes and lock state come from
 logic on CLK and are held with LPC_REQ until LPC_DONE, except the lock, which lifts to end a long wait.
*/
// Our own choice: the Avalon-MM interface to the registers.
//
// Contract
// - configuration register clears to zero on reset.
// - writing one to bit 7 pulses the controller soft reset, bit self-clears.
// - bit 7 always reads zero.
// - policy 00: locked cycle ends with error sync, read zero, write dropped.
// - policy 01: locked cycle ends normally, read zero, write dropped.
// - policy 10: locked cycle gets no answer, no sync.
// - policy 11: locked chip-select cycle held in long wait until unlocked.
// - policy 11: other locked cycles end normally, read zero, write dropped.
// - option one: activation read gives zero when module disabled or locked.
// - option zero: activation read gives the stored activation bit.
// - locked LPC access sets sticky violation flag; write one clears it.
`timescale 1ns/10ps
`default_nettype none
module lapc_top
   import lapc_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [AVS_DATA_W-1:0] AVS_WRITEDATA,
   input wire logic [AVS_BE_W-1:0] AVS_BYTEENABLE,
   output logic [AVS_DATA_W-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic LPC_REQ,
   input wire logic LPC_WRITE,
   input wire logic LPC_LOCKED,
   input wire logic LPC_XCS_TARGET,
   input wire logic LPC_ACT_READ,
   input wire logic LPC_ACT_STORED,
   input wire logic LPC_FAST_DISABLED,
   output logic LPC_DONE,
   output logic [1:0] LPC_RESP_KIND,
   output logic LPC_LONG_WAIT,
   output logic LPC_READ_ZERO,
   output logic LPC_WRITE_DROP,
   output logic LPC_ACT_VALUE,
   output logic CTRL_SOFT_RESET
);
   lapc_policy_t policy_r, policy_nxt;
   logic act_opt_r, act_opt_nxt;
   logic soft_rst_r, soft_rst_nxt;
   logic viol_r, viol_nxt;
   logic waitreq_r, waitreq_nxt;
   logic [AVS_DATA_W-1:0] rdata_r, rdata_nxt;

   lapc_state_t state_r, state_nxt;
   logic done_r, done_nxt;
   lapc_resp_t kind_r, kind_nxt;
   logic lwait_r, lwait_nxt;
   logic rzero_r, rzero_nxt;
   logic wdrop_r, wdrop_nxt;
   logic actval_r, actval_nxt;

   logic bus_req;
   logic bus_take;
   logic [5:0] acc_index;
   logic cfg_wr;
   logic viol_wr_one;
   logic lpc_take;
   logic viol_set;
   logic pol_hold;
   lapc_resp_t pol_kind;
   logic pol_zero;
   logic act_value;
   logic [CFG_W-1:0] cfg_view;

   lapc_policy u_policy (
      .policy(policy_r),
      .locked(LPC_LOCKED),
      .xcs_target(LPC_XCS_TARGET),
      .hold(pol_hold),
      .kind(pol_kind),
      .data_zero(pol_zero)
   );

   // one wait cycle per access; the access takes effect when waitrequest is low
   assign bus_req = AVS_READ | AVS_WRITE;
   assign bus_take = bus_req & ~waitreq_r;
   assign acc_index = lapc_index(AVS_ADDRESS);
   assign cfg_wr = bus_take & AVS_WRITE & AVS_BYTEENABLE[0] & (acc_index == CFG_INDEX);
   assign viol_wr_one = bus_take & AVS_WRITE & AVS_BYTEENABLE[0]
                        & (acc_index == VIOL_INDEX) & AVS_WRITEDATA[VIOL_BIT];

   assign lpc_take = (state_r == ST_IDLE) & LPC_REQ;
   assign viol_set = lpc_take & LPC_LOCKED;

   // bit 7 and the reserved bits are never stored, so they read zero
   always_comb begin
      cfg_view = CFG_RESET;
      cfg_view[POLICY_MSB:POLICY_LSB] = policy_r;
      cfg_view[ACT_OPT_BIT] = act_opt_r;
   end

   always_comb begin
      act_value = LPC_ACT_STORED;
      if (act_opt_r) begin
         act_value = LPC_ACT_STORED & ~LPC_FAST_DISABLED & ~LPC_LOCKED;
      end
      if (!LPC_ACT_READ || LPC_WRITE) begin
         act_value = 1'b0;
      end
   end

   always_comb begin
      waitreq_nxt = 1'b1;
      rdata_nxt = rdata_r;
      if (bus_req && waitreq_r) begin
         waitreq_nxt = 1'b0;
         rdata_nxt = '0;
         if (AVS_READ) begin
            unique case (acc_index)
               CFG_INDEX: rdata_nxt[CFG_W-1:0] = cfg_view;
               VIOL_INDEX: rdata_nxt[VIOL_BIT] = viol_r;
               STAT_INDEX: rdata_nxt[WAIT_BIT] = lwait_r;
               default: rdata_nxt = '0;
            endcase
         end
      end
   end

   always_comb begin
      policy_nxt = policy_r;
      act_opt_nxt = act_opt_r;
      soft_rst_nxt = 1'b0;
      if (cfg_wr) begin
         policy_nxt = lapc_policy_t'(AVS_WRITEDATA[POLICY_MSB:POLICY_LSB]);
         act_opt_nxt = AVS_WRITEDATA[ACT_OPT_BIT];
         soft_rst_nxt = AVS_WRITEDATA[SOFT_RST_BIT];
      end
      // a new violation wins over a clear in the same cycle
      viol_nxt = viol_r;
      if (viol_wr_one) begin
         viol_nxt = 1'b0;
      end
      if (viol_set) begin
         viol_nxt = 1'b1;
      end
   end

   always_comb begin
      state_nxt = state_r;
      done_nxt = 1'b0;
      kind_nxt = kind_r;
      lwait_nxt = lwait_r;
      rzero_nxt = rzero_r;
      wdrop_nxt = wdrop_r;
      actval_nxt = actval_r;
      unique case (state_r)
         ST_IDLE: begin
            if (LPC_REQ) begin
               if (pol_hold) begin
                  state_nxt = ST_WAIT;
                  lwait_nxt = 1'b1;
               end else begin
                  state_nxt = ST_DONE;
                  done_nxt = 1'b1;
                  kind_nxt = pol_kind;
                  rzero_nxt = pol_zero & ~LPC_WRITE;
                  wdrop_nxt = pol_zero & LPC_WRITE;
                  actval_nxt = act_value & ~pol_zero;
               end
            end
         end
         ST_WAIT: begin
            // held until the lock lifts; no timeout, the lock owner must release
            if (!LPC_LOCKED) begin
               state_nxt = ST_DONE;
               done_nxt = 1'b1;
               lwait_nxt = 1'b0;
               kind_nxt = RESP_NORMAL;
               rzero_nxt = 1'b0;
               wdrop_nxt = 1'b0;
               actval_nxt = act_value;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
            lwait_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         policy_r <= lapc_policy_t'(POLICY_RESET);
         act_opt_r <= ACT_OPT_RESET;
         soft_rst_r <= 1'b0;
         viol_r <= VIOL_RESET;
         waitreq_r <= 1'b1;
         rdata_r <= '0;
      end else begin
         policy_r <= policy_nxt;
         act_opt_r <= act_opt_nxt;
         soft_rst_r <= soft_rst_nxt;
         viol_r <= viol_nxt;
         waitreq_r <= waitreq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r <= ST_IDLE;
         done_r <= 1'b0;
         kind_r <= RESP_NORMAL;
         lwait_r <= 1'b0;
         rzero_r <= 1'b0;
         wdrop_r <= 1'b0;
         actval_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         done_r <= done_nxt;
         kind_r <= kind_nxt;
         lwait_r <= lwait_nxt;
         rzero_r <= rzero_nxt;
         wdrop_r <= wdrop_nxt;
         actval_r <= actval_nxt;
      end
   end

   assign AVS_READDATA = rdata_r;
   assign AVS_WAITREQUEST = waitreq_r;
   assign LPC_DONE = done_r;
   assign LPC_RESP_KIND = kind_r;
   assign LPC_LONG_WAIT = lwait_r;
   assign LPC_READ_ZERO = rzero_r;
   assign LPC_WRITE_DROP = wdrop_r;
   assign LPC_ACT_VALUE = actval_r;
   assign CTRL_SOFT_RESET = soft_rst_r;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   logic cfg_rd_take;
   assign cfg_rd_take = bus_take & AVS_READ & (acc_index == CFG_INDEX);

   sequence s_locked_take(lapc_policy_t p);
      lpc_take && LPC_LOCKED && !pol_hold && (policy_r == p);
   endsequence

   sequence s_wait_release;
      (state_r == ST_WAIT) && !LPC_LOCKED;
   endsequence

   soft_pulse_a: assert property (
      cfg_wr && AVS_WRITEDATA[SOFT_RST_BIT] |=> CTRL_SOFT_RESET ##1 !CTRL_SOFT_RESET)
      else $error("soft reset trigger not a single pulse");

   soft_read_a: assert property (
      cfg_rd_take |-> !AVS_READDATA[SOFT_RST_BIT])
      else $error("soft reset bit read back as one");

   reserved_read_a: assert property (
      cfg_rd_take |-> AVS_READDATA[6] == 1'b0 && AVS_READDATA[3:1] == 3'h0
                      && AVS_READDATA[POLICY_MSB:POLICY_LSB] == policy_r)
      else $error("config readback wrong");

   error_policy_a: assert property (
      s_locked_take(POL_ERROR) |=> LPC_DONE && LPC_RESP_KIND == RESP_ERROR
         && (LPC_READ_ZERO != LPC_WRITE_DROP))
      else $error("error policy answer wrong");

   silent_policy_a: assert property (
      s_locked_take(POL_SILENT) |=> LPC_DONE && LPC_RESP_KIND == RESP_NORMAL
         && (LPC_READ_ZERO || LPC_WRITE_DROP))
      else $error("silent policy answer wrong");

   ignore_policy_a: assert property (
      s_locked_take(POL_IGNORE) |=> LPC_DONE && LPC_RESP_KIND == RESP_NONE)
      else $error("ignore policy still answered");

   xcs_hold_a: assert property (
      lpc_take && LPC_LOCKED && LPC_XCS_TARGET && policy_r == POL_XCS_WAIT
         |=> LPC_LONG_WAIT && !LPC_DONE)
      else $error("chip-select cycle not held");

   xcs_release_a: assert property (
      s_wait_release |=> LPC_DONE && !LPC_LONG_WAIT && LPC_RESP_KIND == RESP_NORMAL
         && !LPC_READ_ZERO && !LPC_WRITE_DROP ##1 !LPC_DONE)
      else $error("long wait release wrong");

   other_locked_a: assert property (
      s_locked_take(POL_XCS_WAIT) |=> LPC_DONE && LPC_RESP_KIND == RESP_NORMAL
         && !LPC_LONG_WAIT && (LPC_READ_ZERO || LPC_WRITE_DROP))
      else $error("other locked module answer wrong");

   act_masked_a: assert property (
      lpc_take && !pol_hold && act_opt_r && (LPC_LOCKED || LPC_FAST_DISABLED)
         |=> LPC_DONE && !LPC_ACT_VALUE)
      else $error("masked activation read not zero");

   act_plain_a: assert property (
      lpc_take && !LPC_LOCKED && !act_opt_r && LPC_ACT_READ && !LPC_WRITE
         |=> LPC_ACT_VALUE == $past(LPC_ACT_STORED))
      else $error("activation read not the stored bit");

   viol_sticky_a: assert property (
      viol_set |=> viol_r ##0 (viol_r || $past(viol_wr_one)))
      else $error("violation flag not set");

   viol_hold_a: assert property (
      !viol_set && !viol_wr_one |=> viol_r == $past(viol_r))
      else $error("violation flag changed without cause");

   bus_answer_a: assert property (
      bus_req && waitreq_r |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer timing wrong");
endmodule : lapc_top
`default_nettype wire

//--- core/lapc_pkg.sv
/*
 lapc_pkg: constants and types of the locked-access policy configuration block.
 assumes: compiled before every design file that imports it.
*/
package lapc_pkg;
   localparam int unsigned AVS_ADDR_W = 8;
   localparam int unsigned AVS_DATA_W = 32;
   localparam int unsigned AVS_BE_W = 4;
   localparam int unsigned CFG_W = 8;

   // register indices; byte address is four times the index
   localparam logic [5:0] CFG_INDEX = 6'h01;
   localparam logic [5:0] VIOL_INDEX = 6'h03;
   localparam logic [5:0] STAT_INDEX = 6'h04;

   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   localparam logic [1:0] POLICY_RESET = 2'h0;
   localparam logic ACT_OPT_RESET = 1'b0;
   localparam logic VIOL_RESET = 1'b0;

   localparam int unsigned SOFT_RST_BIT = 7;
   localparam int unsigned POLICY_LSB = 4;
   localparam int unsigned POLICY_MSB = 5;
   localparam int unsigned ACT_OPT_BIT = 0;
   localparam int unsigned VIOL_BIT = 0;
   localparam int unsigned WAIT_BIT = 1;

   typedef enum logic [1:0] {
      POL_ERROR = 2'h0,
      POL_SILENT = 2'h1,
      POL_IGNORE = 2'h2,
      POL_XCS_WAIT = 2'h3
   } lapc_policy_t;

   typedef enum logic [1:0] {
      RESP_NORMAL = 2'h0,
      RESP_ERROR = 2'h1,
      RESP_NONE = 2'h2
   } lapc_resp_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WAIT = 2'h1,
      ST_DONE = 2'h2
   } lapc_state_t;

   function automatic logic [5:0] lapc_index(input logic [AVS_ADDR_W-1:0] addr);
      return addr[AVS_ADDR_W-1:2];
   endfunction : lapc_index
endpackage : lapc_pkg

//--- core/lapc_policy.sv
/*
 lapc_policy: decodes the locked-access policy into the answer for one LPC cycle.
 assumes: purely combinational; the caller registers the results.
*/
`timescale 1ns/10ps
`default_nettype none
module lapc_policy
   import lapc_pkg::*;
(
   input wire lapc_policy_t policy,
   input wire logic locked,
   input wire logic xcs_target,
   output logic hold,
   output lapc_resp_t kind,
   output logic data_zero
);
   always_comb begin
      hold = 1'b0;
      kind = RESP_NORMAL;
      data_zero = 1'b0;
      if (locked) begin
         unique case (policy)
            POL_ERROR: begin
               kind = RESP_ERROR;
               data_zero = 1'b1;
            end
            POL_SILENT: begin
               kind = RESP_NORMAL;
               data_zero = 1'b1;
            end
            POL_IGNORE: begin
               kind = RESP_NONE;
               data_zero = 1'b1;
            end
            POL_XCS_WAIT: begin
               hold = xcs_target;
               data_zero = ~xcs_target;
            end
         endcase
      end
   end
endmodule : lapc_policy
`default_nettype wire

//--- testbench/lapc_host_model.sv
/*
 lapc_host_model: LPC-side requester issuing one cycle at a time.
 assumes: same clock as the block; the answer comes as a one-cycle done pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module lapc_host_model (
   input wire logic clk,
   input wire logic done,
   input wire logic [1:0] kind,
   input wire logic long_wait,
   input wire logic read_zero,
   input wire logic write_drop,
   input wire logic act_value,
   output logic req,
   output logic [5:0] attr
);
   // attr: write, locked, chip-select target, activation read, stored bit, fast-disabled
   initial begin
      req = 1'b0;
      attr = 6'h00;
   end

   task automatic run(input logic [5:0] a, input int rel, output logic [4:0] ans,
         output int lw, output logic ok);
      int n;
      ok = 1'b0;
      lw = 0;
      ans = 5'h00;
      attr <= a;
      req <= 1'b1;
      for (n = 0; n < 200 && !ok; n++) begin
         @(posedge clk);
         if (done === 1'b1) begin
            ok = 1'b1;
            ans = {kind, read_zero, write_drop, act_value};
         end
         if (long_wait === 1'b1)
            lw++;
         // lock lifted by the owner while the cycle is held
         if (lw != 0 && lw == rel)
            attr[4] <= 1'b0;
      end
      req <= 1'b0;
      // released attributes flip, so nothing stale looks valid
      attr <= ~a;
      @(posedge clk);
   endtask : run
endmodule : lapc_host_model
`default_nettype wire

//--- testbench/test_locked_access_policy_config.sv
/*
 test_locked_access_policy_config: self-checking bench for lapc_top.
 assumes: lapc_pkg and lapc_host_model compiled first; one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_locked_access_policy_config
   import lapc_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] rdata;
   logic waitreq, req, done, long_wait, read_zero, write_drop, act_value, soft_rst;
   logic [5:0] attr;
   logic [1:0] kind;
   int fail_count = 0;
   int tests_run = 0;

   always #5 clk = ~clk;

   lapc_top uut (
      .CLK(clk), .ARST_N(arst_n),
      .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .LPC_REQ(req), .LPC_WRITE(attr[5]), .LPC_LOCKED(attr[4]),
      .LPC_XCS_TARGET(attr[3]), .LPC_ACT_READ(attr[2]),
      .LPC_ACT_STORED(attr[1]), .LPC_FAST_DISABLED(attr[0]),
      .LPC_DONE(done), .LPC_RESP_KIND(kind), .LPC_LONG_WAIT(long_wait),
      .LPC_READ_ZERO(read_zero), .LPC_WRITE_DROP(write_drop),
      .LPC_ACT_VALUE(act_value), .CTRL_SOFT_RESET(soft_rst)
   );

   lapc_host_model host (
      .clk(clk), .done(done), .kind(kind), .long_wait(long_wait),
      .read_zero(read_zero), .write_drop(write_drop), .act_value(act_value),
      .req(req), .attr(attr)
   );

   task automatic final_report;
      $display("checks %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one Avalon access; a trailing edge keeps back-to-back strobes apart
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      addr <= a;
      wdata <= d;
      wr_en <= wr;
      rd_en <= !wr;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (waitreq === 1'b0)
            break;
      end
      if (n == 20) begin
         fail_count++;
         final_report();
      end
      q = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic lpc(input logic [5:0] a, input int rel, output logic [4:0] ans,
         output int lw);
      logic ok;
      host.run(a, rel, ans, lw, ok);
      if (!ok) begin
         fail_count++;
         final_report();
      end
   endtask : lpc

   task automatic t_reset;
      logic [31:0] q;
      bus(1'b0, 8'h04, 32'h0, q);
      check("cfg reset", q, 32'h0);
      bus(1'b0, 8'h0C, 32'h0, q);
      check("viol reset", q, 32'h0);
      bus(1'b0, 8'hFC, 32'h0, q);
      check("unmapped read", q, 32'h0);
   endtask : t_reset

   task automatic t_cfg;
      logic [31:0] q;
      bus(1'b1, 8'h04, 32'hFF, q);
      check("soft reset pulse", 32'(soft_rst), 32'h1);
      @(posedge clk);
      check("soft reset ends", 32'(soft_rst), 32'h0);
      bus(1'b0, 8'h04, 32'h0, q);
      check("cfg fields", q, 32'h31);
      be <= 4'h0;
      bus(1'b1, 8'h04, 32'h00, q);
      be <= 4'hF;
      bus(1'b0, 8'h04, 32'h0, q);
      check("byte enable off", q, 32'h31);
   endtask : t_cfg

   task automatic t_policy;
      logic [31:0] q;
      logic [4:0] ans;
      logic [1:0] kexp [4];
      int lw;
      kexp = '{RESP_ERROR, RESP_NORMAL, RESP_NONE, RESP_NORMAL};
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, 8'h04, 32'(p << POLICY_LSB), q);
         for (int w = 0; w < 2; w++) begin
            lpc({w[0], 5'h10}, 0, ans, lw);
            check("locked kind", 32'(ans[4:3]), 32'(kexp[p]));
            if (p != 2)
               check("zero or drop", 32'(ans[2:1]), w ? 32'h1 : 32'h2);
         end
      end
      lpc(6'h00, 0, ans, lw);
      check("unlocked answer", 32'(ans[4:1]), 32'h0);
   endtask : t_policy

   task automatic t_viol;
      logic [31:0] q;
      logic [4:0] ans;
      int lw;
      bus(1'b1, 8'h0C, 32'h0, q);
      bus(1'b0, 8'h0C, 32'h0, q);
      check("viol sticky", q, 32'h1);
      bus(1'b1, 8'h0C, 32'h1, q);
      bus(1'b0, 8'h0C, 32'h0, q);
      check("viol cleared", q, 32'h0);
      lpc(6'h00, 0, ans, lw);
      bus(1'b0, 8'h0C, 32'h0, q);
      check("viol unlocked", q, 32'h0);
   endtask : t_viol

   task automatic t_long_wait;
      logic [31:0] q;
      logic [4:0] ans;
      int lw;
      bus(1'b1, 8'h04, 32'h30, q);
      fork
         lpc(6'h38, 5, ans, lw);
         begin
            repeat (3) @(posedge clk);
            bus(1'b0, 8'h10, 32'h0, q);
            check("wait status", q, 32'h2);
         end
      join
      check("wait cycles", 32'(lw), 32'h6);
      check("wait answer", 32'(ans[4:1]), 32'h0);
   endtask : t_long_wait

   task automatic t_act;
      logic [31:0] q;
      logic [4:0] ans;
      int lw;
      bus(1'b1, 8'h04, 32'h01, q);
      lpc(6'h07, 0, ans, lw);
      check("act fast disabled", 32'(ans[0]), 32'h0);
      lpc(6'h06, 0, ans, lw);
      check("act enabled", 32'(ans[0]), 32'h1);
      lpc(6'h16, 0, ans, lw);
      check("act locked", 32'(ans[0]), 32'h0);
      bus(1'b1, 8'h04, 32'h00, q);
      lpc(6'h07, 0, ans, lw);
      check("act stored", 32'(ans[0]), 32'h1);
   endtask : t_act

   // reset in mid-run, with fields and flag away from their reset values
   task automatic t_midreset;
      logic [31:0] q;
      logic [4:0] ans;
      int lw;
      bus(1'b1, 8'h04, 32'h31, q);
      lpc(6'h10, 0, ans, lw);
      bus(1'b0, 8'h0C, 32'h0, q);
      check("viol before reset", q, 32'h1);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("reset waitrequest", 32'(waitreq), 32'h1);
      check("reset done", 32'(done), 32'h0);
      arst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 8'h04, 32'h0, q);
      check("cfg after reset", q, 32'h0);
      bus(1'b0, 8'h0C, 32'h0, q);
      check("viol after reset", q, 32'h0);
   endtask : t_midreset

   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_cfg();
      t_policy();
      t_viol();
      t_long_wait();
      t_act();
      t_midreset();
      final_report();
   end
endmodule : test_locked_access_policy_config
`default_nettype wire
